/* File: hw/msps_dev.sv */
`timescale 1ns/1ps
module msps_dev import msps_pkg::*; #(
  parameter int DIV = CONV_DIV
) (
  input wire logic clk_i,              // System clock.
  input wire logic rst_i,              // Asynchronous reset, active high.
  msps_link_if.dev link,               // Serial link from the host.
  input wire logic comp_i,             // Integrator comparator, high when positive.
  output msps_phase_t phase_o,         // Phase driving the analog switches.
  output logic deint_neg_o,            // Deintegrate polarity is negative.
  output logic eoc_o,                  // Conversion complete, idle at count zero.
  output logic line50_o,               // Line mode of the running conversion.
  output logic [RES_W-1:0] result_o    // Latched signed result.
);
  logic [3:0] sy0_r;
  logic [3:0] sy1_r;
  logic [3:0] dly_r;
  wire cs_n_s = sy1_r[0];
  wire sclk_s = sy1_r[1];
  wire mosi_s = sy1_r[2];
  wire comp_s = sy1_r[3];
  wire cs_fall = dly_r[0] & ~cs_n_s;
  wire cs_rise = ~dly_r[0] & cs_n_s;
  wire sclk_rise = ~dly_r[1] & sclk_s & ~cs_n_s;
  wire sclk_fall = dly_r[1] & ~sclk_s & ~cs_n_s;

  logic [9:0] div_r;
  logic tick_r;
  logic run_r;
  logic start_pend_r;
  logic mode50_r;
  logic [1:0] rsel_r;
  logic [SEQ_W-1:0] seq_r;
  logic [1:0] dslot_r;
  logic [RES_W-1:0] acc_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [3:0] nbit_r;

  logic [SEQ_W-1:0] n_nxt;
  msps_phase_t slot_nxt;
  logic dstart_nxt;
  logic [1:0] didx_nxt;
  logic [RES_W-1:0] step;
  logic [7:0] status;

  assign link.miso = tx_r[7];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy0_r <= 4'h1;
      sy1_r <= 4'h1;
      dly_r <= 4'h1;
    end else begin
      sy0_r <= {comp_i, link.mosi, link.sclk, link.cs_n};
      sy1_r <= sy0_r;
      dly_r <= sy1_r;
    end
  end

  // One converter clock per DIV system clocks, so 2048 counts take a sixteenth second.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 10'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 10'(DIV - 1));
      div_r <= (div_r == 10'(DIV - 1)) ? 10'h000 : div_r + 10'h001;
    end
  end

  // Maps the next count onto its phase slot.
  always_comb begin
    int off;
    off = 0;
    n_nxt = seq_r + 11'h001;
    slot_nxt = PH_ZERO;
    dstart_nxt = 1'b0;
    didx_nxt = 2'h0;
    if (32'(n_nxt) <= (line50_o ? ZI_PRE_50 : ZI_PRE_60)) begin
      slot_nxt = PH_ZERO;
    end else if (32'(n_nxt) <= INT_END) begin
      slot_nxt = PH_INTEG;
    end else if (32'(n_nxt) >= POST_START) begin
      slot_nxt = PH_ZERO;
    end else if (32'(n_nxt) <= D1_END) begin
      slot_nxt = PH_DEINT;
      dstart_nxt = (32'(n_nxt) == INT_END + 1);
    end else begin
      off = 32'(n_nxt) - D1_END - 1;
      if ((off % BLK_LEN) < GAIN_LEN) begin
        slot_nxt = PH_GAIN;
      end else begin
        slot_nxt = PH_DEINT;
        dstart_nxt = ((off % BLK_LEN) == GAIN_LEN);
        didx_nxt = 2'(off / BLK_LEN + 1);
      end
    end
  end

  // Each finer deintegrate slot weighs an eighth of the one before.
  always_comb begin
    unique case (dslot_r)
      2'h0: step = 20'h0_0200;
      2'h1: step = 20'h0_0040;
      2'h2: step = 20'h0_0008;
      2'h3: step = 20'h0_0001;
    endcase
  end

  // All phase changes happen on a converter tick of the one clock.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      seq_r <= '0;
      phase_o <= PH_ZERO;
      deint_neg_o <= 1'b0;
      dslot_r <= 2'h0;
      acc_r <= '0;
      eoc_o <= 1'b1;
      line50_o <= 1'b0;
      result_o <= '0;
    end else if (tick_r) begin
      if (!run_r) begin
        phase_o <= PH_ZERO;
        if (start_pend_r) begin
          run_r <= 1'b1;
          seq_r <= 11'h001;
          eoc_o <= 1'b0;
          acc_r <= '0;
          line50_o <= mode50_r;
        end
      end else begin
        if (phase_o == PH_DEINT) begin
          acc_r <= deint_neg_o ? acc_r - step : acc_r + step;
        end
        if (seq_r == 11'(SEQ_LEN - 1)) begin
          run_r <= 1'b0;
          seq_r <= '0;
          eoc_o <= 1'b1;
          result_o <= acc_r;
          phase_o <= PH_ZERO;
        end else begin
          seq_r <= n_nxt;
          if (dstart_nxt) begin
            phase_o <= PH_DEINT;
            deint_neg_o <= ~comp_s;
            dslot_r <= didx_nxt;
          end else if (slot_nxt == PH_DEINT) begin
            // After the crossing the slot rests until its last count.
            if (phase_o == PH_DEINT && comp_s == deint_neg_o) begin
              phase_o <= PH_REST;
            end
          end else begin
            phase_o <= slot_nxt;
          end
        end
      end
    end
  end

  // The line mode used by a conversion is the one in force when it starts.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_pend_r <= 1'b0;
      mode50_r <= 1'b0;
      rsel_r <= RSEL_STATUS;
    end else begin
      if (tick_r && !run_r && start_pend_r) begin
        start_pend_r <= 1'b0;
      end
      if (cs_rise && nbit_r == 4'h8) begin
        rsel_r <= rx_r[CMD_RSEL_LSB +: 2];
        mode50_r <= rx_r[CMD_MODE50_BIT];
        if (rx_r[CMD_START_BIT]) begin
          start_pend_r <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    status = 8'h00;
    status[ST_EOC_BIT] = eoc_o;
    status[ST_INT_BIT] = (phase_o == PH_INTEG);
    status[2:0] = result_o[2:0];
  end

  // The byte sent is the one selected by the previous exchange.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      nbit_r <= 4'h0;
    end else if (cs_fall) begin
      nbit_r <= 4'h0;
      unique case (rsel_r)
        RSEL_LOW: tx_r <= result_o[10:3];
        RSEL_HIGH: tx_r <= result_o[18:11];
        default: tx_r <= status;
      endcase
    end else if (sclk_rise) begin
      rx_r <= {rx_r[6:0], mosi_s};
      if (nbit_r != 4'hF) begin
        nbit_r <= nbit_r + 4'h1;
      end
    end else if (sclk_fall) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end
endmodule

/* File: inc/msps_pkg.sv */
package msps_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CONV_CLK_HZ = 32_768;
  localparam int CONV_DIV = CLK_HZ / CONV_CLK_HZ;
  localparam int SEQ_LEN = 2048;
  localparam int SEQ_W = 11;
  localparam int ZI_PRE_60 = 111;
  localparam int ZI_PRE_50 = 1;
  localparam int INT_60 = 545;
  localparam int INT_50 = 655;
  localparam int INT_END = ZI_PRE_60 + INT_60;
  localparam int D1_LEN = 1047;
  localparam int GAIN_LEN = 8;
  localparam int DN_LEN = 100;
  localparam int ZI_POST = 20;
  localparam int D1_END = INT_END + D1_LEN;
  localparam int BLK_LEN = GAIN_LEN + DN_LEN;
  localparam int POST_START = SEQ_LEN - ZI_POST;
  localparam int RES_W = 20;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_MODE50_BIT = 1;
  localparam int CMD_RSEL_LSB = 2;
  localparam logic [1:0] RSEL_STATUS = 2'h0;
  localparam logic [1:0] RSEL_LOW = 2'h1;
  localparam logic [1:0] RSEL_HIGH = 2'h2;
  localparam int ST_EOC_BIT = 7;
  localparam int ST_INT_BIT = 6;
  localparam int SCLK_HALF = 8;
  localparam int GAP_S = 2;
  localparam int GAP_CYC = GAP_S * CLK_HZ;
  localparam int FAST_RATE_CPS = 16;
  typedef enum logic [2:0] {PH_ZERO, PH_INTEG, PH_DEINT, PH_REST, PH_GAIN} msps_phase_t;
endpackage

/* File: inc/msps_link_if.sv */
`timescale 1ns/1ps
interface msps_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

/* File: hw/msps_host.sv */
`timescale 1ns/1ps
module msps_host import msps_pkg::*; #(
  parameter int GAP_CYCLES = GAP_CYC
) (
  input wire logic clk_i,           // System clock.
  input wire logic rst_i,           // Asynchronous reset, active high.
  msps_link_if.host link,           // Serial link to the converter.
  input wire logic req_i,           // Start one exchange.
  input wire logic [7:0] cmd_i,     // Command byte to send.
  input wire logic fast_rate_i,     // Conversions run faster than the fast limit.
  output logic busy_o,              // Exchange in progress.
  output logic done_o,              // One-cycle pulse at exchange end.
  output logic [7:0] rdata_o,       // Byte returned by the exchange.
  output logic stale_o              // Next reading follows a long gap.
);
  typedef enum {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_END, H_HOLD} msps_hst_t;
  msps_hst_t st_r;
  logic [4:0] cnt_r;
  logic [2:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic [1:0] miso_sy_r;
  logic cs_n_r;
  logic sclk_r;
  logic [31:0] gap_r;
  wire half_done = (cnt_r == 5'(SCLK_HALF - 1));

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.mosi = tx_r[7];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      miso_sy_r <= 2'h0;
    end else begin
      miso_sy_r <= {miso_sy_r[0], link.miso};
    end
  end

  // The command goes out as given except that fast_rate_i forces the line mode bit; sequencing reads is up to the user.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= H_IDLE;
      cnt_r <= 5'h0;
      bit_r <= 3'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      cnt_r <= half_done ? 5'h0 : cnt_r + 5'h1;
      unique case (st_r)
        H_IDLE: begin
          cnt_r <= 5'h0;
          if (req_i) begin
            tx_r <= cmd_i;
            tx_r[CMD_MODE50_BIT] <= cmd_i[CMD_MODE50_BIT] | fast_rate_i;
            cs_n_r <= 1'b0;
            busy_o <= 1'b1;
            bit_r <= 3'h0;
            st_r <= H_SETUP;
          end
        end
        H_SETUP, H_LOW: begin
          if (half_done) begin
            sclk_r <= 1'b1;
            rx_r <= {rx_r[6:0], miso_sy_r[1]};
            st_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done) begin
            sclk_r <= 1'b0;
            if (bit_r == 3'h7) begin
              st_r <= H_END;
            end else begin
              bit_r <= bit_r + 3'h1;
              tx_r <= {tx_r[6:0], 1'b0};
              st_r <= H_LOW;
            end
          end
        end
        H_END: begin
          if (half_done) begin
            cs_n_r <= 1'b1;
            done_o <= 1'b1;
            rdata_o <= rx_r;
            st_r <= H_HOLD;
          end
        end
        H_HOLD: begin
          // The link stays quiet between exchanges.
          if (half_done) begin
            busy_o <= 1'b0;
            st_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Flags the conversion started after a long idle gap.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_r <= 32'h0000_0000;
      stale_o <= 1'b0;
    end else if (st_r == H_IDLE && req_i && cmd_i[CMD_START_BIT]) begin
      stale_o <= (gap_r >= 32'(GAP_CYCLES));
      gap_r <= 32'h0000_0000;
    end else if (gap_r != 32'hFFFF_FFFF) begin
      gap_r <= gap_r + 32'h0000_0001;
    end
  end
endmodule

/* File: tb/msps_link_asserts.sv */
`timescale 1ns/1ps
module msps_link_asserts import msps_pkg::*; #(
  parameter int DIV = CONV_DIV
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic cs_n, // Select.
  input wire logic sclk, // Link clock.
  input wire logic mosi, // Host data.
  input wire logic miso, // Device data.
  input wire msps_phase_t phase_o, // Phase.
  input wire logic eoc_o, // End flag.
  input wire logic line50_o // Mode.
);
  // Clocks since the end flag dropped, zero while it is high.
  int sc_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sc_r <= 0;
    end else begin
      sc_r <= eoc_o ? 0 : sc_r + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sclk_idle_a: assert property (cs_n |-> !sclk) else $error("link clock runs while deselected");
  frame_len_a: assert property ($fell(cs_n) |-> ##135 !cs_n ##1 cs_n) else $error("frame length wrong");
  sclk_half_a: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk) else $error("clock high time wrong");
  mosi_hold_a: assert property (sclk |-> $stable(mosi)) else $error("host data moved in high clock");
  miso_hold_a: assert property (sclk |-> $stable(miso)) else $error("device data moved in high clock");
  idle_zero_a: assert property (eoc_o |-> phase_o == PH_ZERO) else $error("idle not zeroing");
  eoc_start_a: assert property ($fell(eoc_o) |-> phase_o == PH_ZERO) else $error("start not zeroing");
  pre_zero_a: assert property (phase_o == PH_INTEG && $past(phase_o) != PH_INTEG
    |-> sc_r == (line50_o ? ZI_PRE_50 : ZI_PRE_60) * DIV) else $error("lead zero length wrong");
  integ_end_a: assert property ($past(phase_o) == PH_INTEG && phase_o != PH_INTEG
    |-> sc_r == INT_END * DIV) else $error("integrate end wrong");
  post_zero_a: assert property (phase_o == PH_ZERO && $past(phase_o) != PH_ZERO && !eoc_o
    |-> sc_r == (POST_START - 1) * DIV) else $error("tail zero start wrong");
  conv_len_a: assert property ($rose(eoc_o) |-> sc_r == (SEQ_LEN - 1) * DIV) else $error("cycle length wrong");
endmodule

/* File: tb/test_multislope_phase_sequencer.sv */
`timescale 1ns/1ps
module test_multislope_phase_sequencer import msps_pkg::*;;
  localparam int DV = 4;
  // The model's crossing is seen on the third tick of every deintegrate slot.
  localparam int EXP_RES = 3 * (512 + 64 + 8 + 1);
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [7:0] cmd_i = 8'h00;
  logic fast_rate_i = 1'b0;
  logic comp_i = 1'b1;
  logic busy_o, done_o, stale_o, deint_neg_o, eoc_o, line50_o;
  logic [7:0] rdata_o, rb;
  logic [RES_W-1:0] result_o;
  msps_phase_t phase_o;
  int n_fail = 0;
  int checks = 0;
  int dc = 0;
  int g = 0;
  int sc = 0;
  int t_on = 0;
  int t_off = 0;
  int t_end = 0;
  msps_phase_t ph_q = PH_ZERO;
  always #20 clk_i = ~clk_i;
  msps_link_if link_if();
  msps_host #(.GAP_CYCLES(200)) msps_host_inst(.clk_i(clk_i), .rst_i(rst_i), .link(link_if), .req_i(req_i),
    .cmd_i(cmd_i), .fast_rate_i(fast_rate_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .stale_o(stale_o));
  msps_dev #(.DIV(DV)) msps_dev_inst(.clk_i(clk_i), .rst_i(rst_i), .link(link_if), .comp_i(comp_i),
    .phase_o(phase_o), .deint_neg_o(deint_neg_o), .eoc_o(eoc_o), .line50_o(line50_o), .result_o(result_o));
  msps_link_asserts #(.DIV(DV)) msps_link_asserts_inst(.clk_i(clk_i), .rst_i(rst_i), .cs_n(link_if.cs_n),
    .sclk(link_if.sclk), .mosi(link_if.mosi), .miso(link_if.miso), .phase_o(phase_o), .eoc_o(eoc_o),
    .line50_o(line50_o));
  // The integrator stays positive and crosses zero eight clocks into every deintegrate slot.
  always @(posedge clk_i) begin
    dc <= (phase_o == PH_DEINT) ? dc + 1 : 0;
    comp_i <= !(phase_o == PH_DEINT && dc >= 8);
    if (phase_o == PH_GAIN) begin
      g <= g + 1;
    end
    sc <= eoc_o ? 0 : sc + 1;
    if (!eoc_o) begin
      t_end <= sc + 1;
    end
    if (phase_o == PH_INTEG && ph_q != PH_INTEG) begin
      t_on <= sc;
    end
    if (phase_o != PH_INTEG && ph_q == PH_INTEG) begin
      t_off <= sc;
    end
    ph_q <= phase_o;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_eoc(input logic v);
    int i;
    for (i = 0; i < 20000 && eoc_o !== v; i++) @(negedge clk_i);
    if (eoc_o !== v) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic xchg(input logic [7:0] c);
    int i;
    @(posedge clk_i);
    req_i <= 1'b1;
    cmd_i <= c;
    @(posedge clk_i);
    req_i <= 1'b0;
    for (i = 0; i < 400 && done_o !== 1'b1; i++) @(negedge clk_i);
    rb = rdata_o;
    if (i == 400) begin
      n_fail++;
      summarize();
    end
    for (i = 0; i < 400 && busy_o !== 1'b0; i++) @(negedge clk_i);
    if (i == 400) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic conv(input logic [7:0] c, input int pre, input int integ);
    int g0;
    g0 = g;
    xchg(c);
    wait_eoc(1'b0);
    wait_eoc(1'b1);
    chk("lead zero", t_on, pre * DV);
    chk("integrate", t_off - t_on, integ * DV);
    chk("conv length", t_end, (SEQ_LEN - 1) * DV);
    chk("gain clocks", g - g0, 3 * GAIN_LEN * DV);
    chk("idle phase", phase_o, PH_ZERO);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset eoc", eoc_o, 1'b1);
    chk("reset phase", phase_o, PH_ZERO);
    chk("reset result", result_o, 32'h0000_0000);
    conv(8'h01, ZI_PRE_60, INT_60);
    chk("first reply", rb, 8'h80);
    chk("mode 60", line50_o, 1'b0);
    chk("result", result_o, EXP_RES);
    chk("polarity", deint_neg_o, 1'b0);
    xchg(8'h04);
    chk("status", rb, {5'h10, EXP_RES[2:0]});
    xchg(8'h08);
    chk("low byte", rb, EXP_RES[10:3]);
    xchg(8'h00);
    chk("high byte", rb, EXP_RES[18:11]);
    conv(8'h03, ZI_PRE_50, INT_50);
    chk("stale", stale_o, 1'b1);
    chk("mode 50", line50_o, 1'b1);
    @(posedge clk_i);
    fast_rate_i <= 1'b1;
    conv(8'h01, ZI_PRE_50, INT_50);
    chk("forced 50", line50_o, 1'b1);
    xchg(8'h01);
    xchg(8'h01);
    chk("no stale", stale_o, 1'b0);
    summarize();
  end
endmodule
